// File: rtl/cpcs_top.sv
/*
 cpcs_top: register file and control for the sample-clock synthesizer,
 vco calibration and lock report, companion clock divider, full-scale code.
 Assumes clk is the reference clock input at 250 MHz and the lock level
 from the analog vco arrives asynchronously.
*/
`timescale 1ns/100ps
module cpcs_top
	import cpcs_pkg::*;
#(
	parameter int CAL_LEN = cpcs_pkg::CAL_CYCLES
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// serial control port
	input  wire logic        sclk_pin,
	input  wire logic        csb_n_pin,
	input  wire logic        sdio_in,
	output logic             sdio_out,
	output logic             sdio_oe_n,
	output logic             sdo_out,
	// analog vco
	input  wire logic        vco_lock_pin,
	// synthesizer settings
	output logic             synth_enable,
	output logic [1:0]       vco_out_div,
	output logic [2:0]       ref_predivide,
	output logic [5:0]       feedback_divide,
	output logic [8:0]       ratio_num,
	output logic [4:0]       ratio_den,
	output logic             vco_cal_busy,
	output logic             pll_locked,
	// companion clock
	output logic [2:0]       companion_div,
	output logic             companion_strobe,
	// converter controls
	output logic [7:0]       full_scale_code,
	output logic [7:0]       converter_power,
	output logic [7:0]       clock_receiver_power,
	output logic [7:0]       lane_phy_reset,
	output logic [7:0]       boot_loader_enable,
	output logic             soft_reset_active,
	output logic             four_wire_mode
);
	import cpcs_pkg::*;

	localparam int CW = $clog2(CAL_LEN + 1);

	typedef enum logic [3:0] {
		I_SRST, I_FSC, I_CONV, I_CLKRX, I_ODIV, I_BYP,
		I_PHY, I_BOOT, I_CAL, I_PDIV, I_CFB, I_LOCK, I_NONE
	} cpcs_idx_t;

	function automatic cpcs_idx_t f_index(input logic [14:0] a);
		case (a)
			A_SOFT_RST:  f_index = I_SRST;
			A_FSC:       f_index = I_FSC;
			A_CONV_PWR:  f_index = I_CONV;
			A_CLKRX_PWR: f_index = I_CLKRX;
			A_OUT_DIV:   f_index = I_ODIV;
			A_BYPASS:    f_index = I_BYP;
			A_PHY_RST:   f_index = I_PHY;
			A_BOOT:      f_index = I_BOOT;
			A_CAL_CTRL:  f_index = I_CAL;
			A_PREDIV:    f_index = I_PDIV;
			A_COMP_FB:   f_index = I_CFB;
			A_LOCK:      f_index = I_LOCK;
			default:     f_index = I_NONE;
		endcase
	endfunction : f_index

	logic        reg_wr, reg_rd;
	logic [14:0] reg_addr;
	logic [7:0]  reg_wdata, reg_rdata;
	cpcs_idx_t   wr_idx;

	cpcs_spi_slave u_spi (
		.clk       (clk),
		.resetn    (resetn),
		.sclk_pin  (sclk_pin),
		.csb_n_pin (csb_n_pin),
		.sdio_in   (sdio_in),
		.sdio_out  (sdio_out),
		.sdio_oe_n (sdio_oe_n),
		.sdo_out   (sdo_out),
		.four_wire (four_wire_mode),
		.wr_pulse  (reg_wr),
		.rd_pulse  (reg_rd),
		.addr      (reg_addr),
		.wdata     (reg_wdata),
		.rdata     (reg_rdata)
	);

	logic [7:0] srst_ff, fsc_ff, conv_ff, clkrx_ff, odiv_ff, byp_ff;
	logic [7:0] phy_ff, boot_ff, cal_ff, pdiv_ff, cfb_ff;
	logic [7:0] nxt_srst, nxt_fsc, nxt_conv, nxt_clkrx, nxt_odiv, nxt_byp;
	logic [7:0] nxt_phy, nxt_boot, nxt_cal, nxt_pdiv, nxt_cfb;
	logic       srst_on, cal_start;

	always_comb begin
		wr_idx    = f_index(reg_addr);
		srst_on   = srst_ff[SRST_BIT] | srst_ff[SRST_MIR_BIT];
		nxt_srst  = srst_ff;
		nxt_fsc   = fsc_ff;
		nxt_conv  = conv_ff;
		nxt_clkrx = clkrx_ff;
		nxt_odiv  = odiv_ff;
		nxt_byp   = byp_ff;
		nxt_phy   = phy_ff;
		nxt_boot  = boot_ff;
		nxt_cal   = cal_ff;
		nxt_pdiv  = pdiv_ff;
		nxt_cfb   = cfb_ff;
		cal_start = 1'b0;
		if (reg_wr) begin
			case (wr_idx)
				I_SRST:  nxt_srst = reg_wdata;
				I_FSC:   nxt_fsc = reg_wdata;
				I_CONV:  nxt_conv = reg_wdata;
				I_CLKRX: nxt_clkrx = reg_wdata;
				I_ODIV:  nxt_odiv = reg_wdata;
				I_BYP:   nxt_byp = reg_wdata;
				I_PHY:   nxt_phy = reg_wdata;
				I_BOOT:  nxt_boot = reg_wdata;
				I_CAL:   nxt_cal = reg_wdata;
				I_PDIV:  nxt_pdiv = reg_wdata;
				I_CFB:   nxt_cfb = reg_wdata;
				default: nxt_srst = srst_ff;
			endcase
			// only a written 1 to 0 step launches calibration
			cal_start = (wr_idx == I_CAL) && cal_ff[CAL_TRIG_BIT] && !reg_wdata[CAL_TRIG_BIT];
		end
		// soft reset holds every other register at its default until released
		if (srst_on) begin
			nxt_fsc   = R_FSC;
			nxt_conv  = R_CONV_PWR;
			nxt_clkrx = R_CLKRX_PWR;
			nxt_odiv  = R_OUT_DIV;
			nxt_byp   = R_BYPASS;
			nxt_phy   = R_PHY_RST;
			nxt_boot  = R_BOOT;
			nxt_cal   = R_CAL_CTRL;
			nxt_pdiv  = R_PREDIV;
			nxt_cfb   = R_COMP_FB;
			cal_start = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			srst_ff  <= R_SOFT_RST;
			fsc_ff   <= R_FSC;
			conv_ff  <= R_CONV_PWR;
			clkrx_ff <= R_CLKRX_PWR;
			odiv_ff  <= R_OUT_DIV;
			byp_ff   <= R_BYPASS;
			phy_ff   <= R_PHY_RST;
			boot_ff  <= R_BOOT;
			cal_ff   <= R_CAL_CTRL;
			pdiv_ff  <= R_PREDIV;
			cfb_ff   <= R_COMP_FB;
		end else begin
			srst_ff  <= nxt_srst;
			fsc_ff   <= nxt_fsc;
			conv_ff  <= nxt_conv;
			clkrx_ff <= nxt_clkrx;
			odiv_ff  <= nxt_odiv;
			byp_ff   <= nxt_byp;
			phy_ff   <= nxt_phy;
			boot_ff  <= nxt_boot;
			cal_ff   <= nxt_cal;
			pdiv_ff  <= nxt_pdiv;
			cfb_ff   <= nxt_cfb;
		end
	end

	// calibration, lock and ratio state
	cpcs_cal_t     cal_state_ff, nxt_cal_state;
	logic [CW-1:0] cal_cnt_ff, nxt_cal_cnt;
	logic [1:0]    lock_s_ff, nxt_lock_s;
	logic          lock_ff, nxt_lock;
	logic [8:0]    num_ff, nxt_num;
	logic [4:0]    den_ff, nxt_den;
	logic [2:0]    pre_m;
	logic [1:0]    out_d;

	always_comb begin
		nxt_lock_s    = {lock_s_ff[0], vco_lock_pin};
		nxt_cal_state = cal_state_ff;
		nxt_cal_cnt   = cal_cnt_ff;
		case (cal_state_ff)
			CAL_RUN: begin
				nxt_cal_cnt = cal_cnt_ff + 1'b1;
				if (cal_cnt_ff == CW'(CAL_LEN - 1)) begin
					nxt_cal_state = CAL_DONE;
				end
			end
			CAL_IDLE, CAL_DONE: nxt_cal_cnt = '0;
			default: nxt_cal_state = CAL_IDLE;
		endcase
		if (cal_start) begin
			nxt_cal_state = CAL_RUN;
			nxt_cal_cnt   = '0;
		end
		if (srst_on) begin
			nxt_cal_state = CAL_IDLE;
		end
		// lock only counts once calibration has settled on the synthesizer path
		nxt_lock = (cal_state_ff == CAL_DONE) && lock_s_ff[1] && !byp_ff[BYPASS_BIT] && !srst_on;
		pre_m    = {1'b0, pdiv_ff[PREDIV_LSB+:2]} + 3'h1;
		// field value 3 has no defined divisor; it is clamped to three
		out_d    = (odiv_ff[OUT_DIV_LSB+:2] == 2'h3) ? 2'h3 : odiv_ff[OUT_DIV_LSB+:2] + 2'h1;
		nxt_num  = {cfb_ff[FB_LSB+:FB_W], 3'h0};
		nxt_den  = 5'(pre_m * out_d);
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cal_state_ff <= CAL_IDLE;
			cal_cnt_ff   <= '0;
			lock_s_ff    <= 2'h0;
			lock_ff      <= 1'b0;
			num_ff       <= 9'h000;
			den_ff       <= 5'h00;
		end else begin
			cal_state_ff <= nxt_cal_state;
			cal_cnt_ff   <= nxt_cal_cnt;
			lock_s_ff    <= nxt_lock_s;
			lock_ff      <= nxt_lock;
			num_ff       <= nxt_num;
			den_ff       <= nxt_den;
		end
	end

	// companion clock divider, one strobe every ratio cycles
	logic [1:0] cdiv_cnt_ff, nxt_cdiv_cnt;
	logic       cstrobe_ff, nxt_cstrobe;
	logic [2:0] cdiv;

	always_comb begin
		cdiv         = {1'b0, cfb_ff[COMP_LSB+:2]} + 3'h1;
		nxt_cstrobe  = ({1'b0, cdiv_cnt_ff} >= cdiv - 3'h1);
		nxt_cdiv_cnt = nxt_cstrobe ? 2'h0 : cdiv_cnt_ff + 2'h1;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cdiv_cnt_ff <= 2'h0;
			cstrobe_ff  <= 1'b0;
		end else begin
			cdiv_cnt_ff <= nxt_cdiv_cnt;
			cstrobe_ff  <= nxt_cstrobe;
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		case (f_index(reg_addr))
			I_SRST:  reg_rdata = srst_ff;
			I_FSC:   reg_rdata = fsc_ff;
			I_CONV:  reg_rdata = conv_ff;
			I_CLKRX: reg_rdata = clkrx_ff;
			I_ODIV:  reg_rdata = odiv_ff;
			I_BYP:   reg_rdata = byp_ff;
			I_PHY:   reg_rdata = phy_ff;
			I_BOOT:  reg_rdata = boot_ff;
			I_CAL:   reg_rdata = cal_ff;
			I_PDIV:  reg_rdata = pdiv_ff;
			I_CFB:   reg_rdata = cfb_ff;
			I_LOCK:  reg_rdata = 8'(lock_ff) << LOCK_BIT;
			default: reg_rdata = 8'h00;
		endcase
	end

	assign synth_enable         = !byp_ff[BYPASS_BIT];
	assign vco_out_div          = out_d;
	assign ref_predivide        = pre_m;
	assign feedback_divide      = cfb_ff[FB_LSB+:FB_W];
	assign ratio_num            = num_ff;
	assign ratio_den            = den_ff;
	assign vco_cal_busy         = (cal_state_ff == CAL_RUN);
	assign pll_locked           = lock_ff;
	assign companion_div        = cdiv;
	assign companion_strobe     = cstrobe_ff;
	assign full_scale_code      = fsc_ff;
	assign converter_power      = conv_ff;
	assign clock_receiver_power = clkrx_ff;
	assign lane_phy_reset       = phy_ff;
	assign boot_loader_enable   = boot_ff;
	assign soft_reset_active    = srst_on;
	assign four_wire_mode       = srst_ff[FOUR_WIRE_BIT];

	// checks
	logic [2:0] gap_ff, nxt_gap;
	logic       span_ok_ff, nxt_span_ok;

	always_comb begin
		nxt_gap     = cstrobe_ff ? 3'h0 : gap_ff + 3'h1;
		nxt_span_ok = cstrobe_ff ? 1'b1 : span_ok_ff;
		if ((reg_wr && wr_idx == I_CFB) || srst_on) begin
			nxt_span_ok = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			gap_ff     <= 3'h0;
			span_ok_ff <= 1'b0;
		end else begin
			gap_ff     <= nxt_gap;
			span_ok_ff <= nxt_span_ok;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_synth_en;
		reg_wr && wr_idx == I_BYP && !srst_on |=> synth_enable == !$past(reg_wdata[BYPASS_BIT]);
	endproperty
	a_synth_en: assert property (p_synth_en) else $error("synthesizer enable wrong after bypass write");

	property p_out_div;
		reg_wr && wr_idx == I_ODIV && !srst_on && reg_wdata[1:0] != 2'h3
			|=> vco_out_div == $past(reg_wdata[1:0]) + 2'h1;
	endproperty
	a_out_div: assert property (p_out_div) else $error("vco output divisor wrong");

	property p_ratio;
		// the ratio flops hold zero for the first edge after reset, so that edge is skipped
		$past(resetn) |-> ratio_num == {$past(feedback_divide), 3'h0}
			&& ratio_den == 5'($past(ref_predivide) * $past(vco_out_div));
	endproperty
	a_ratio: assert property (p_ratio) else $error("sample clock ratio wrong");

	property p_prediv;
		reg_wr && wr_idx == I_PDIV && !srst_on |=> ref_predivide == {1'b0, $past(reg_wdata[1:0])} + 3'h1;
	endproperty
	a_prediv: assert property (p_prediv) else $error("predivide ratio wrong");

	property p_cal_start;
		cal_start |=> vco_cal_busy ##1 !pll_locked;
	endproperty
	a_cal_start: assert property (p_cal_start) else $error("calibration did not start");

	property p_cal_len;
		$rose(cal_state_ff == CAL_DONE) |-> $past(cal_cnt_ff) == CW'(CAL_LEN - 1);
	endproperty
	a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");

	property p_lock;
		$rose(pll_locked) |-> $past(cal_state_ff == CAL_DONE && synth_enable);
	endproperty
	a_lock: assert property (p_lock) else $error("lock reported without calibration");

	property p_comp;
		companion_strobe && span_ok_ff |-> gap_ff == companion_div - 3'h1;
	endproperty
	a_comp: assert property (p_comp) else $error("companion strobe spacing wrong");

	property p_fsc;
		reg_wr && wr_idx == I_FSC && !srst_on |=> full_scale_code == $past(reg_wdata);
	endproperty
	a_fsc: assert property (p_fsc) else $error("full-scale code not stored");

	property p_srst;
		reg_wr && wr_idx == I_SRST && reg_wdata == 8'h81
			|=> soft_reset_active ##1 (full_scale_code == R_FSC && !vco_cal_busy && !pll_locked);
	endproperty
	a_srst: assert property (p_srst) else $error("soft reset did not restore defaults");

	c_cal_done: cover property ($rose(cal_state_ff == CAL_DONE));
	c_locked:   cover property ($rose(pll_locked));
	c_read:     cover property (reg_rd && wr_idx == I_LOCK);
	c_four:     cover property ($rose(four_wire_mode));
endmodule : cpcs_top

// File: rtl/cpcs_pkg.sv
/*
 cpcs_pkg: register map, reset values, field positions, serial frame and
 timing constants for the sample-clock synthesizer setup block.
 Assumes a 250 MHz block clock taken from the reference clock input.
*/
package cpcs_pkg;
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;

	// register offsets
	localparam logic [14:0] A_SOFT_RST  = 15'h0000;
	localparam logic [14:0] A_FSC       = 15'h005A;
	localparam logic [14:0] A_CONV_PWR  = 15'h0090;
	localparam logic [14:0] A_CLKRX_PWR = 15'h0091;
	localparam logic [14:0] A_OUT_DIV   = 15'h0094;
	localparam logic [14:0] A_BYPASS    = 15'h0095;
	localparam logic [14:0] A_PHY_RST   = 15'h0206;
	localparam logic [14:0] A_BOOT      = 15'h0705;
	localparam logic [14:0] A_CAL_CTRL  = 15'h0792;
	localparam logic [14:0] A_PREDIV    = 15'h0793;
	localparam logic [14:0] A_COMP_FB   = 15'h0799;
	localparam logic [14:0] A_LOCK      = 15'h07B5;

	// reset values
	localparam logic [7:0] R_SOFT_RST  = 8'h00;
	localparam logic [7:0] R_FSC       = 8'h28;
	localparam logic [7:0] R_CONV_PWR  = 8'h00;
	localparam logic [7:0] R_CLKRX_PWR = 8'h00;
	localparam logic [7:0] R_OUT_DIV   = 8'h00;
	localparam logic [7:0] R_BYPASS    = 8'h00;
	localparam logic [7:0] R_PHY_RST   = 8'h00;
	localparam logic [7:0] R_BOOT      = 8'h00;
	localparam logic [7:0] R_CAL_CTRL  = 8'h00;
	localparam logic [7:0] R_PREDIV    = 8'h18;
	localparam logic [7:0] R_COMP_FB   = 8'h08;

	// field positions
	localparam int SRST_BIT      = 0;
	localparam int SRST_MIR_BIT  = 7;
	localparam int FOUR_WIRE_BIT = 3;
	localparam int BYPASS_BIT    = 0;
	localparam int CAL_TRIG_BIT  = 1;
	localparam int LOCK_BIT      = 0;
	localparam int OUT_DIV_LSB   = 0;
	localparam int PREDIV_LSB    = 0;
	localparam int FB_LSB        = 0;
	localparam int FB_W          = 6;
	localparam int COMP_LSB      = 6;

	// serial frame: r/w bit, 15 address bits, 8 data bits
	localparam logic [4:0] SPI_INSTR_BITS = 5'h10;
	localparam logic [4:0] SPI_FRAME_BITS = 5'h18;

	// timing
	localparam int CLK_PERIOD_PS = 4000;
	localparam int CAL_TIME_US   = 100;
	localparam int CAL_CYCLES    = CAL_TIME_US * 1000000 / CLK_PERIOD_PS;

	typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_DONE} cpcs_cal_t;
endpackage : cpcs_pkg

// File: rtl/cpcs_spi_slave.sv
/*
 cpcs_spi_slave: serial control port slave, one byte per frame.
 Assumes serial pins far slower than clk; sclk passes three flip-flops, the other pins two.
*/
`timescale 1ns/100ps
module cpcs_spi_slave
	import cpcs_pkg::*;
(
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       resetn,
	// serial pins
	input  wire logic                       sclk_pin,
	input  wire logic                       csb_n_pin,
	input  wire logic                       sdio_in,
	output logic                            sdio_out,
	output logic                            sdio_oe_n,
	output logic                            sdo_out,
	input  wire logic                       four_wire,
	// register access
	output logic                            wr_pulse,
	output logic                            rd_pulse,
	output logic [cpcs_pkg::ADDR_W-1:0]     addr,
	output logic [cpcs_pkg::DATA_W-1:0]     wdata,
	input  wire logic [cpcs_pkg::DATA_W-1:0] rdata
);
	import cpcs_pkg::*;

	logic [2:0]  sclk_s_ff, nxt_sclk_s;
	logic [1:0]  csb_s_ff, nxt_csb_s;
	logic [1:0]  sdio_s_ff, nxt_sdio_s;
	logic [4:0]  cnt_ff, nxt_cnt;
	logic [15:0] shift_ff, nxt_shift;
	logic [14:0] addr_ff, nxt_addr;
	logic        rw_ff, nxt_rw;
	logic [7:0]  wdata_ff, nxt_wdata;
	logic [7:0]  out_ff, nxt_out;
	logic        sdio_ff, nxt_sdio;
	logic        oe_n_ff, nxt_oe_n;
	logic        sdo_ff, nxt_sdo;
	logic        wr_ff, nxt_wr;
	logic        rd_ff, nxt_rd;
	logic        rise, fall, din, in_data;

	always_comb begin
		// bit 0 is the first stage and only feeds bit 1
		nxt_sclk_s = {sclk_s_ff[1:0], sclk_pin};
		nxt_csb_s  = {csb_s_ff[0], csb_n_pin};
		nxt_sdio_s = {sdio_s_ff[0], sdio_in};
		rise       = sclk_s_ff[1] & ~sclk_s_ff[2];
		fall       = ~sclk_s_ff[1] & sclk_s_ff[2];
		din        = sdio_s_ff[1];
		in_data    = rw_ff && (cnt_ff >= SPI_INSTR_BITS) && (cnt_ff < SPI_FRAME_BITS);
		nxt_cnt    = cnt_ff;
		nxt_shift  = shift_ff;
		nxt_addr   = addr_ff;
		nxt_rw     = rw_ff;
		nxt_wdata  = wdata_ff;
		nxt_out    = out_ff;
		nxt_sdio   = sdio_ff;
		nxt_oe_n   = oe_n_ff;
		nxt_sdo    = sdo_ff;
		nxt_wr     = 1'b0;
		nxt_rd     = 1'b0;
		if (csb_s_ff[1]) begin
			nxt_cnt  = 5'h00;
			nxt_rw   = 1'b0;
			nxt_oe_n = 1'b1;
			nxt_sdio = 1'b0;
			nxt_sdo  = 1'b0;
		end else begin
			if (rise && cnt_ff < SPI_FRAME_BITS) begin
				nxt_cnt   = cnt_ff + 5'h01;
				nxt_shift = {shift_ff[14:0], din};
				if (cnt_ff == SPI_INSTR_BITS - 5'h01) begin
					nxt_rw   = shift_ff[14];
					nxt_addr = {shift_ff[13:0], din};
					nxt_rd   = shift_ff[14];
				end
				if (cnt_ff == SPI_FRAME_BITS - 5'h01 && !rw_ff) begin
					nxt_wr    = 1'b1;
					nxt_wdata = {shift_ff[6:0], din};
				end
			end
			if (rd_ff) begin
				nxt_out = rdata;
			end
			// read data leaves on falling edges, msb first
			if (fall) begin
				if (in_data) begin
					if (four_wire) begin
						nxt_sdo = out_ff[7];
					end else begin
						nxt_sdio = out_ff[7];
						nxt_oe_n = 1'b0;
					end
					nxt_out = {out_ff[6:0], 1'b0};
				end else begin
					nxt_oe_n = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			sclk_s_ff <= 3'h0;
			csb_s_ff  <= 2'h3;
			sdio_s_ff <= 2'h0;
			cnt_ff    <= 5'h00;
			shift_ff  <= 16'h0000;
			addr_ff   <= 15'h0000;
			rw_ff     <= 1'b0;
			wdata_ff  <= 8'h00;
			out_ff    <= 8'h00;
			sdio_ff   <= 1'b0;
			oe_n_ff   <= 1'b1;
			sdo_ff    <= 1'b0;
			wr_ff     <= 1'b0;
			rd_ff     <= 1'b0;
		end else begin
			sclk_s_ff <= nxt_sclk_s;
			csb_s_ff  <= nxt_csb_s;
			sdio_s_ff <= nxt_sdio_s;
			cnt_ff    <= nxt_cnt;
			shift_ff  <= nxt_shift;
			addr_ff   <= nxt_addr;
			rw_ff     <= nxt_rw;
			wdata_ff  <= nxt_wdata;
			out_ff    <= nxt_out;
			sdio_ff   <= nxt_sdio;
			oe_n_ff   <= nxt_oe_n;
			sdo_ff    <= nxt_sdo;
			wr_ff     <= nxt_wr;
			rd_ff     <= nxt_rd;
		end
	end

	assign sdio_out  = sdio_ff;
	assign sdio_oe_n = oe_n_ff;
	assign sdo_out   = sdo_ff;
	assign wr_pulse  = wr_ff;
	assign rd_pulse  = rd_ff;
	assign addr      = addr_ff;
	assign wdata     = wdata_ff;
endmodule : cpcs_spi_slave

// File: tb/cpcs_host.sv
/*
 cpcs_host: serial port host model, one byte per frame.
 Assumes clk is the block clock; pins change on its falling edge.
*/
`timescale 1ns/100ps
module cpcs_host (
	// clock
	input  wire logic clk,
	// serial pins
	output logic      sclk_pin,
	output logic      csb_n_pin,
	output logic      sdio_in,
	input  wire logic sdio_out,
	input  wire logic sdio_oe_n,
	input  wire logic sdo_out,
	input  wire logic four_wire
);
	logic drv;

	// the device wins the shared wire while it drives
	assign sdio_in = sdio_oe_n ? drv : sdio_out;

	initial begin
		sclk_pin  = 1'b0;
		csb_n_pin = 1'b1;
		drv       = 1'b0;
	end

	task automatic gap(input int n);
		repeat (n) @(negedge clk);
	endtask : gap

	// r/w bit, 15 address bits, data byte, msb first; 8 clk per half bit
	task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd, output logic [7:0] q);
		logic [23:0] f;
		f = {rd, a, wd};
		q = 8'h00;
		gap(1);
		csb_n_pin = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			// a released line toggles so a stale bit never reads as data
			drv = (rd && i < 8) ? ~drv : f[i];
			gap(8);
			if (i < 8)
				q[i] = four_wire ? sdo_out : sdio_in;
			sclk_pin = 1'b1;
			gap(8);
			sclk_pin = 1'b0;
		end
		gap(8);
		csb_n_pin = 1'b1;
		gap(8);
	endtask : xfer
endmodule : cpcs_host

// File: tb/cpcs_top_test.sv
/*
 cpcs_top_test: self-checking bench for cpcs_top.
 Assumes cpcs_host as the serial host and a short calibration length.
*/
`timescale 1ns/100ps
module cpcs_top_test;
	import cpcs_pkg::*;
	localparam int CAL_LEN = 60;
	localparam int MAX_CYC = 40000;
	typedef struct packed {
		logic [14:0] a;
		logic [7:0]  wd;
		logic [7:0]  rd;
		logic [8:0]  pv;
	} cpcs_row_t;

	logic       clk, resetn, sclk_pin, csb_n_pin, sdio_in, sdio_out, sdio_oe_n, sdo_out;
	logic       vco_lock_pin, synth_enable, vco_cal_busy, pll_locked, companion_strobe;
	logic       soft_reset_active, four_wire_mode;
	logic [1:0] vco_out_div;
	logic [2:0] ref_predivide, companion_div;
	logic [5:0] feedback_divide;
	logic [8:0] ratio_num, pv;
	logic [4:0] ratio_den;
	logic [7:0] full_scale_code, converter_power, clock_receiver_power, lane_phy_reset, boot_loader_enable, q;
	int         err_total = 0;
	int         checks = 0;
	int         cyc = 0;
	int         n;
	cpcs_row_t  rows [17] = '{
		'{A_FSC, 8'hFF, 8'hFF, 9'h0FF}, '{A_FSC, 8'h00, 8'h00, 9'h000},
		'{A_PREDIV, 8'h18, 8'h18, 9'h001}, '{A_PREDIV, 8'h19, 8'h19, 9'h002},
		'{A_PREDIV, 8'h1A, 8'h1A, 9'h003}, '{A_PREDIV, 8'h1B, 8'h1B, 9'h004},
		'{A_OUT_DIV, 8'h00, 8'h00, 9'h001}, '{A_OUT_DIV, 8'h01, 8'h01, 9'h002},
		'{A_OUT_DIV, 8'h02, 8'h02, 9'h003}, '{A_COMP_FB, 8'h02, 8'h02, 9'h042},
		'{A_COMP_FB, 8'h72, 8'h72, 9'h0B2}, '{A_COMP_FB, 8'hB0, 8'hB0, 9'h0F0},
		'{A_COMP_FB, 8'hD9, 8'hD9, 9'h119}, '{A_BYPASS, 8'h01, 8'h01, 9'h000},
		'{A_BYPASS, 8'h00, 8'h00, 9'h001}, '{A_LOCK, 8'hFF, 8'h00, 9'h000},
		'{15'h0123, 8'hAA, 8'h00, 9'h000}};

	cpcs_top #(.CAL_LEN(CAL_LEN)) cpcs_top_inst (.clk(clk), .resetn(resetn), .sclk_pin(sclk_pin),
		.csb_n_pin(csb_n_pin), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
		.sdo_out(sdo_out), .vco_lock_pin(vco_lock_pin), .synth_enable(synth_enable),
		.vco_out_div(vco_out_div), .ref_predivide(ref_predivide), .feedback_divide(feedback_divide),
		.ratio_num(ratio_num), .ratio_den(ratio_den), .vco_cal_busy(vco_cal_busy),
		.pll_locked(pll_locked), .companion_div(companion_div), .companion_strobe(companion_strobe),
		.full_scale_code(full_scale_code), .converter_power(converter_power),
		.clock_receiver_power(clock_receiver_power), .lane_phy_reset(lane_phy_reset),
		.boot_loader_enable(boot_loader_enable), .soft_reset_active(soft_reset_active),
		.four_wire_mode(four_wire_mode));

	cpcs_host cpcs_host_inst (.clk(clk), .sclk_pin(sclk_pin), .csb_n_pin(csb_n_pin), .sdio_in(sdio_in),
		.sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .sdo_out(sdo_out), .four_wire(four_wire_mode));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		cpcs_host_inst.xfer(1'b0, a, d, q);
	endtask : wr

	task automatic rd(input logic [14:0] a);
		cpcs_host_inst.xfer(1'b1, a, 8'h00, q);
	endtask : rd

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test

	// the ceiling is about twice the expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc == MAX_CYC) begin
			err_total++;
			stop_test();
		end
	end

	initial begin
		resetn       = 1'b0;
		vco_lock_pin = 1'b0;
		repeat (16) @(negedge clk);
		resetn = 1'b1;
		repeat (4) @(negedge clk);
		chk("reset_outs", {full_scale_code, ref_predivide, feedback_divide, companion_div, vco_out_div},
			{R_FSC, 3'd1, R_COMP_FB[5:0], 3'd1, 2'd1});
		chk("reset_state", {synth_enable, pll_locked, vco_cal_busy, ratio_num, ratio_den},
			{3'b100, 9'd64, 5'd1});
		rd(A_PREDIV);
		chk("three_wire_read", q, R_PREDIV);
		$display("test reset done");

		wr(A_SOFT_RST, 8'h81);
		chk("soft_reset_set", soft_reset_active, 1'b1);
		wr(A_FSC, 8'h55);
		chk("fsc_held", full_scale_code, R_FSC);
		wr(A_SOFT_RST, 8'h3C);
		chk("soft_reset_release", {soft_reset_active, four_wire_mode}, 2'b01);
		wr(A_CLKRX_PWR, 8'h00);
		wr(A_PHY_RST, 8'h01);
		wr(A_BOOT, 8'h01);
		wr(A_CONV_PWR, 8'h00);
		chk("power_up", {lane_phy_reset, boot_loader_enable, clock_receiver_power, converter_power},
			32'h01010000);
		$display("test power_up done");

		// predivide writes keep the upper bits at 0x06
		for (int i = 0; i < 17; i++) begin
			wr(rows[i].a, rows[i].wd);
			case (rows[i].a)
				A_FSC:     pv = {1'b0, full_scale_code};
				A_PREDIV:  pv = {6'h00, ref_predivide};
				A_OUT_DIV: pv = {7'h00, vco_out_div};
				A_COMP_FB: pv = {companion_div, feedback_divide};
				A_BYPASS:  pv = {8'h00, synth_enable};
				default:   pv = {8'h00, pll_locked};
			endcase
			chk("row_port", pv, rows[i].pv);
			rd(rows[i].a);
			chk("row_read", q, rows[i].rd);
		end
		chk("ratio", {ratio_num, ratio_den}, {9'd200, 5'd12});
		$display("test rows done");

		n = 0;
		repeat (40) begin
			@(negedge clk);
			n += companion_strobe;
		end
		chk("companion_pulses", n, 10);
		$display("test companion done");

		vco_lock_pin = 1'b1;
		wr(A_CAL_CTRL, 8'h02);
		chk("cal_on_rise", vco_cal_busy, 1'b0);
		wr(A_CAL_CTRL, 8'h00);
		chk("cal_on_fall", vco_cal_busy, 1'b1);
		n = 0;
		while (vco_cal_busy !== 1'b0 && n < 100) begin
			@(negedge clk);
			n++;
		end
		repeat (4) @(negedge clk);
		chk("locked", pll_locked, 1'b1);
		rd(A_LOCK);
		chk("lock_read", q, 8'h01);
		wr(A_CAL_CTRL, 8'h00);
		chk("cal_no_fall", vco_cal_busy, 1'b0);
		vco_lock_pin = 1'b0;
		repeat (4) @(negedge clk);
		chk("lock_lost", pll_locked, 1'b0);
		$display("test calibration done");
		stop_test();
	end
endmodule : cpcs_top_test
